/* File: hdl/spp_ctrl.sv */
// Purpose: Pointer, read/write and restart control of a clocked sequential memory port
// Assumes: All port inputs are driven by logic on core_clk; the array lives here
// Notes:   Accesses use the pointer as it stands at the edge; loads take effect after it
//
// Operation
// - A low pointer load or buffer start strobe at a rising edge loads the pointer.
// - A high count enable at a rising edge leaves the pointer unchanged.
// - The cycle right after a pointer load never increments the pointer.
// - The cycle right after a buffer start load counts normally.
// - Chip select low with read/write high at a rising edge registers the addressed word out after that edge.
// - Chip select low with read/write low writes the addressed word, also after a read.
// - Once write is clocked in, data outputs stay off until read is clocked in again.
// - Reset forces the read/write state to write, keeping outputs off.
// - After reset, read data appears after the edge that captures read/write high.
// - Reset sets the pointer to zero so counted accesses run 0, 1, 2 onward.
// - A stopped port restarts when the random port writes zero to bit 4 at command 100.

`timescale 1ns/1ps

module spp_ctrl
    import spp_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF
) (
    input  wire logic              core_clk,            // Sequential clock
    input  wire logic              sys_rst,             // Sync reset, high
    input  wire logic              pointer_load_n,      // Load pointer from load_address
    input  wire logic              buffer_one_start_n,  // Load pointer from buffer one start
    input  wire logic              buffer_two_start_n,  // Load pointer from buffer two start
    input  wire logic              count_enable_n,      // Advance pointer, low
    input  wire logic              seq_chip_select_n,   // Access this cycle, low
    input  wire logic              seq_read_write_n,    // High read, low write
    input  wire logic              seq_output_enable_n, // Output drive enable, low
    input  wire logic [ADDR_W-1:0] load_address,        // Pointer load value
    input  wire logic [ADDR_W-1:0] buffer_one_addr,     // Buffer one start address
    input  wire logic [ADDR_W-1:0] buffer_two_addr,     // Buffer two start address
    input  wire logic [DATA_W-1:0] seq_data_in,         // Write data
    input  wire logic              stop_request,        // Enter stop mode, pulse
    input  wire logic              rand_cmd_n,          // Random port command select, low
    input  wire logic              rand_chip_enable,    // Random port chip enable pin level
    input  wire logic              rand_write,          // Random port write strobe, pulse
    input  wire logic [2:0]        rand_addr,           // Random port command address
    input  wire logic              rand_release_bit,    // Random port data bit 4
    output logic      [DATA_W-1:0] seq_data_out,        // Read data
    output logic                   seq_data_oe_n,       // Data drive enable, low drives
    output logic      [ADDR_W-1:0] seq_pointer,         // Current address pointer
    output logic                   seq_stopped          // Port in stop mode
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
        $error("ADDR_W must lie between 1 and 16");
    end
    if (DATA_W < 1) begin : g_bad_data
        $error("DATA_W must be at least 1");
    end
    if (RESTART_CYC >= (1 << RCV_W)) begin : g_bad_rcv
        $error("RESTART_CYC does not fit the recovery counter");
    end

    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] next_ptr;
    logic              skip_inc;
    logic              next_skip_inc;
    logic              rw_read;
    logic              next_rw_read;
    logic              stopped;
    logic              next_stopped;
    logic [RCV_W-1:0]  rcv_cnt;
    logic [RCV_W-1:0]  next_rcv_cnt;
    logic [DATA_W-1:0] next_data_out;
    logic              next_oe_n;
    logic              active;
    logic              any_load;
    logic              restart_cmd;
    logic              do_write;
    logic [DATA_W-1:0] cur_word;

    assign cur_word = mem[ptr];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        restart_cmd   = rand_write && !rand_cmd_n && rand_chip_enable
                        && (rand_addr == CMD_RESTART_ADDR) && !rand_release_bit;
        active        = !stopped && (rcv_cnt == '0);
        any_load      = !pointer_load_n || !buffer_one_start_n || !buffer_two_start_n;
        next_ptr      = ptr;
        next_skip_inc = 1'b0;
        next_rw_read  = rw_read;
        next_stopped  = stopped;
        next_rcv_cnt  = rcv_cnt;
        next_data_out = seq_data_out;
        do_write      = 1'b0;

        if (restart_cmd) begin
            next_stopped = 1'b0;
            next_rcv_cnt = RCV_W'(RESTART_CYC);
        end else if (stop_request) begin
            next_stopped = 1'b1;
        end else if (rcv_cnt != '0) begin
            next_rcv_cnt = rcv_cnt - 1'b1;
        end

        if (active) begin
            if (!pointer_load_n) begin
                next_ptr      = load_address;
                next_skip_inc = 1'b1;
            end else if (!buffer_one_start_n) begin
                next_ptr      = buffer_one_addr;
            end else if (!buffer_two_start_n) begin
                next_ptr      = buffer_two_addr;
            end else if (!count_enable_n && !skip_inc) begin
                next_ptr      = ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
            // A high count enable keeps next_ptr == ptr

            if (!seq_chip_select_n) begin
                next_rw_read = seq_read_write_n;
                if (seq_read_write_n) begin
                    next_data_out = cur_word;
                end else begin
                    do_write = 1'b1;
                end
            end
        end

        next_oe_n = !(next_rw_read && !seq_output_enable_n);

        if (sys_rst) begin
            next_ptr      = ADDR_W'(PTR_RST);
            next_skip_inc = 1'b0;
            next_rw_read  = RW_RST_READ;
            next_stopped  = STOP_RST;
            next_rcv_cnt  = '0;
            next_data_out = '0;
            next_oe_n     = 1'b1;
            do_write      = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        ptr           <= next_ptr;
        skip_inc      <= next_skip_inc;
        rw_read       <= next_rw_read;
        stopped       <= next_stopped;
        rcv_cnt       <= next_rcv_cnt;
        seq_data_out  <= next_data_out;
        seq_data_oe_n <= next_oe_n;
        seq_pointer   <= next_ptr;
        seq_stopped   <= next_stopped;
    end

    // Array write port
    always_ff @(posedge core_clk) begin
        if (do_write) begin
            mem[ptr] <= seq_data_in;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ptr_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && !pointer_load_n |=> ptr == $past(load_address))
        else $error("Pointer did not take the load address");

    a_ptr_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && !any_load && count_enable_n && !restart_cmd |=> ptr == $past(ptr))
        else $error("Pointer moved with count enable high");

    a_load_no_inc: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && !pointer_load_n ##1 (active && !any_load) |=> ptr == $past(ptr))
        else $error("Pointer advanced right after a pointer load");

    a_start_counts: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && pointer_load_n && !buffer_one_start_n
        ##1 (active && !any_load && !count_enable_n)
        |=> ptr == $past(ptr) + {{(ADDR_W-1){1'b0}}, 1'b1})
        else $error("Pointer failed to count after a buffer start");

    a_read_word: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && !seq_chip_select_n && seq_read_write_n
        |=> seq_data_out == $past(cur_word))
        else $error("Read data does not match the addressed word");

    a_write_word: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && !seq_chip_select_n && !seq_read_write_n
        |=> mem[$past(ptr)] == $past(seq_data_in))
        else $error("Write data not stored at the pointer");

    a_write_hides: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && !seq_chip_select_n && !seq_read_write_n
        ##1 (seq_chip_select_n || !active) |=> seq_data_oe_n)
        else $error("Outputs driven while in write state");

    a_reset_state: assert property (@(posedge core_clk)
        sys_rst |=> seq_data_oe_n && !rw_read && ptr == '0 && !seq_stopped)
        else $error("Reset did not force write state and pointer zero");

    a_first_read: assert property (@(posedge core_clk)
        sys_rst ##1 (!sys_rst && !seq_chip_select_n && seq_read_write_n
        && !seq_output_enable_n && active)
        |=> !seq_data_oe_n && seq_data_out == $past(cur_word))
        else $error("First read after reset not presented");

    a_restart_go: assert property (@(posedge core_clk) disable iff (sys_rst)
        restart_cmd |=> !seq_stopped ##0 (rcv_cnt != '0) ##[1:8] active)
        else $error("Restart command did not release the port");

endmodule : spp_ctrl

/* File: hdl/spp_pkg.sv */
// Purpose: Shared constants for the sequential port pointer control block
// Assumes: One clock, core_clk at 250 MHz
// Notes:   Figures are in the unit named by each constant

package spp_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W_DEF    = 12;
    localparam int          DATA_W_DEF    = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [11:0] PTR_RST       = 12'h000;
    localparam logic        RW_RST_READ   = 1'b0;
    localparam logic        STOP_RST      = 1'b0;

    // ------------------------------------------------------------
    // Random port buffer command
    // ------------------------------------------------------------
    localparam logic [2:0]  CMD_RESTART_ADDR = 3'h4;
    localparam int          CMD_RELEASE_BIT  = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_PS    = 4000;
    localparam int          RESTART_NS       = 13;
    localparam int          RESTART_CYC      =
        ((RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
        ((RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int          RCV_W            = 3;

endpackage : spp_pkg

/* File: dv/spp_host_model.sv */
// Purpose: Far side of the sequential port, a host that clocks strobes into it
// Assumes: Driven 1 ns after each rising edge, held through the next edge
// Notes:   Control word bits: load, buf1, buf2, count, select, read/write, oe
`timescale 1ns/1ps

module spp_host_model
    import spp_pkg::*;
(
    input  wire logic        core_clk,            // Clock
    output logic             pointer_load_n,      // Pointer load strobe
    output logic             buffer_one_start_n,  // Buffer one start
    output logic             buffer_two_start_n,  // Buffer two start
    output logic             count_enable_n,      // Count enable
    output logic             seq_chip_select_n,   // Chip select
    output logic             seq_read_write_n,    // Read/write
    output logic             seq_output_enable_n, // Output enable
    output logic [11:0]      load_address,        // Pointer load value
    output logic [15:0]      seq_data_in          // Write data
);
    initial begin
        {pointer_load_n, buffer_one_start_n, buffer_two_start_n, count_enable_n} = 4'hF;
        {seq_chip_select_n, seq_read_write_n} = 2'h3;
        seq_output_enable_n = 1'b1;
        load_address        = 12'h000;
        seq_data_in         = 16'h0000;
    end

    // One cycle: hold all lines through the edge, return 1 ns after it
    task automatic step(input logic [6:0] ctl, input logic [11:0] addr,
                        input logic [15:0] data);
        {pointer_load_n, buffer_one_start_n, buffer_two_start_n, count_enable_n,
         seq_chip_select_n, seq_read_write_n, seq_output_enable_n} = ctl;
        load_address = addr;
        seq_data_in  = data;
        @(posedge core_clk);
        #1;
    endtask

    // Select and read/write stay high while the port recovers
    task automatic idle(input int n);
        repeat (n) step(7'h7F, 12'h000, 16'h5A5A);
    endtask
endmodule // spp_host_model

/* File: dv/test_spp_ctrl.sv */
// Purpose: Self-checking bench for the sequential port control
// Assumes: Host model drives the port; bench drives reset, stop and command
// Notes:   Checks are made 1 ns after the edge that answers
`timescale 1ns/1ps

module test_spp_ctrl;
    import spp_pkg::*;
    localparam logic [6:0] WR_C = 7'h71, RD_C = 7'h72, RD_H = 7'h7A, WR_OE = 7'h78;
    localparam logic [6:0] LD_C = 7'h37, CNT = 7'h77, B1_C = 7'h57, B2_C = 7'h67;
    logic        core_clk, sys_rst, stop_request, rand_cmd_n, rand_chip_enable;
    logic        rand_write, rand_release_bit, ld_n, b1_n, b2_n, cnt_n, cs_n, rw_n, oe_n;
    logic [2:0]  rand_addr;
    logic [11:0] load_addr, seq_pointer;
    logic [15:0] data_in, seq_data_out;
    logic        seq_data_oe_n, seq_stopped;
    int          bad_count = 0, compares = 0, cycles = 0;

    spp_host_model spp_host_model_i (.core_clk(core_clk), .pointer_load_n(ld_n),
        .buffer_one_start_n(b1_n), .buffer_two_start_n(b2_n), .count_enable_n(cnt_n),
        .seq_chip_select_n(cs_n), .seq_read_write_n(rw_n), .seq_output_enable_n(oe_n),
        .load_address(load_addr), .seq_data_in(data_in));
    spp_ctrl spp_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .pointer_load_n(ld_n),
        .buffer_one_start_n(b1_n), .buffer_two_start_n(b2_n), .count_enable_n(cnt_n),
        .seq_chip_select_n(cs_n), .seq_read_write_n(rw_n), .seq_output_enable_n(oe_n),
        .load_address(load_addr), .buffer_one_addr(12'h100), .buffer_two_addr(12'h200),
        .seq_data_in(data_in), .stop_request(stop_request), .rand_cmd_n(rand_cmd_n),
        .rand_chip_enable(rand_chip_enable), .rand_write(rand_write), .rand_addr(rand_addr),
        .rand_release_bit(rand_release_bit), .seq_data_out(seq_data_out),
        .seq_data_oe_n(seq_data_oe_n), .seq_pointer(seq_pointer), .seq_stopped(seq_stopped));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic ptr(input logic [11:0] exp);
        chk("pointer", {4'h0, exp}, {4'h0, seq_pointer});
    endtask

    task automatic cmd(input logic bit4);
        {rand_write, rand_release_bit} = {1'b1, bit4};
        spp_host_model_i.step(7'h7F, 12'h000, 16'h5A5A);
        rand_write = 1'b0;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        {sys_rst, stop_request, rand_cmd_n, rand_chip_enable, rand_write} = 5'h16;
        {rand_addr, rand_release_bit} = {CMD_RESTART_ADDR, 1'b1};
        repeat (16) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        ptr(12'h000);
        chk("oe", 16'h1, {15'h0, seq_data_oe_n});
        for (int i = 0; i < 4; i++) begin
            spp_host_model_i.step(WR_C, 12'h000, 16'hA000 + i[15:0]);
            ptr(i[11:0] + 12'h001);
        end
        $display("test counted writes done");
        spp_host_model_i.step(LD_C, 12'h001, 16'h0000);
        ptr(12'h001);
        spp_host_model_i.step(CNT, 12'h000, 16'h0000);
        ptr(12'h001);
        spp_host_model_i.step(RD_C, 12'h000, 16'h0000);
        chk("read data", 16'hA001, seq_data_out);
        chk("oe", 16'h0, {15'h0, seq_data_oe_n});
        spp_host_model_i.step(WR_OE, 12'h000, 16'hB002);
        chk("oe", 16'h1, {15'h0, seq_data_oe_n});
        spp_host_model_i.step(WR_OE, 12'h000, 16'hB102);
        ptr(12'h002);
        spp_host_model_i.step(RD_H, 12'h000, 16'h0000);
        chk("read data", 16'hB102, seq_data_out);
        $display("test load and read/write done");
        spp_host_model_i.step(B1_C, 12'h000, 16'h0000);
        spp_host_model_i.step(CNT, 12'h000, 16'h0000);
        ptr(12'h101);
        spp_host_model_i.step(B2_C, 12'h000, 16'h0000);
        spp_host_model_i.step(CNT, 12'h000, 16'h0000);
        ptr(12'h201);
        spp_host_model_i.step(LD_C, 12'hFFF, 16'h0000);
        spp_host_model_i.step(CNT, 12'h000, 16'h0000);
        spp_host_model_i.step(CNT, 12'h000, 16'h0000);
        ptr(12'h000);
        $display("test buffer starts and wrap done");
        stop_request = 1'b1;
        spp_host_model_i.step(7'h7F, 12'h000, 16'h5A5A);
        stop_request = 1'b0;
        chk("stopped", 16'h1, {15'h0, seq_stopped});
        spp_host_model_i.step(LD_C, 12'h123, 16'h0000);
        rand_cmd_n = 1'b0;
        cmd(1'b1);
        ptr(12'h000);
        chk("stopped", 16'h1, {15'h0, seq_stopped});
        rand_addr = 3'h5;
        cmd(1'b0);
        chk("stopped", 16'h1, {15'h0, seq_stopped});
        rand_addr = CMD_RESTART_ADDR;
        cmd(1'b0);
        rand_cmd_n = 1'b1;
        chk("stopped", 16'h0, {15'h0, seq_stopped});
        spp_host_model_i.idle(RESTART_CYC);
        spp_host_model_i.step(LD_C, 12'h123, 16'h0000);
        ptr(12'h123);
        $display("test stop and restart done");
        sys_rst = 1'b1;
        spp_host_model_i.step(7'h7F, 12'h000, 16'h5A5A);
        sys_rst = 1'b0;
        ptr(12'h000);
        chk("oe", 16'h1, {15'h0, seq_data_oe_n});
        spp_host_model_i.step(RD_C, 12'h000, 16'h0000);
        chk("read data", 16'hA000, seq_data_out);
        spp_host_model_i.step(RD_C, 12'h000, 16'h0000);
        chk("read data", 16'hA001, seq_data_out);
        $display("test second reset done");
        end_of_test();
    end
endmodule // test_spp_ctrl
